// file: hw/packed24_pixel_unpacker.v
/*
 * Packed 24-bit pixel port: unpacks N pixels from M pixel-bus words, aligns
 * groups to blanking, makes the return and shift clocks, and latches the
 * legacy VGA port. Assumes a classic Wishbone master and a graphics
 * accelerator that drives bus and blanking right after each load-clock rise.
 */
// The address map and the Wishbone slave port were chosen for this implementation.
`include "packed24_pixel_unpacker_map.vh"

module packed24_pixel_unpacker (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [31:0] wb_dat_i,
    input  wire [3:0]  wb_sel_i,
    input  wire        wb_we_i,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    input  wire        pixel_load_clock_i,
    input  wire        system_blank_in_i,
    input  wire [63:0] pixel_bus_i,
    input  wire        vga_clock_in_i,
    input  wire [7:0]  vga_pixel_in_i,
    input  wire        vga_blank_in_i,
    input  wire        vga_hsync_in_i,
    input  wire        vga_vsync_in_i,
    output reg         return_clock_o,
    output reg         shift_clock_o,
    output reg  [23:0] pixel_o,
    output reg         pixel_valid_o,
    output reg         blank_o,
    output reg         palette_lookup_o,
    output reg         port_select_enable_o,
    output reg         vga_source_o,
    output reg  [7:0]  vga_pixel_o,
    output reg         vga_blank_o,
    output reg         vga_hsync_o,
    output reg         vga_vsync_o
);
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_WAIT = 3'b010;
    localparam [2:0] ST_ACT  = 3'b100;

    function [3:0] grp_pixels;
        input bus64;
        input five;
        begin
            if (bus64)
                grp_pixels = five ? 4'd5 : 4'd8;
            else
                grp_pixels = five ? 4'd5 : 4'd4;
        end
    endfunction

    function [3:0] grp_words;
        input bus64;
        input five;
        begin
            if (bus64)
                grp_words = five ? 4'd2 : 4'd3;
            else
                grp_words = five ? 4'd4 : 4'd3;
        end
    endfunction

    // register file
    reg  [7:0]   tcc_q;
    reg  [7:0]   mux_q;
    reg  [7:0]   misc_q;
    reg  [7:0]   clkc_q;
    reg  [7:0]   latch_q;

    // link side state
    reg  [2:0]   state_q;
    reg          wait_cnt_q;
    reg  [1:0]   widx_q;
    reg  [191:0] asm_q;
    reg  [191:0] group_q;
    reg  [191:0] seq_q;
    reg          have_group_q;
    reg  [63:0]  bus_hold_q;
    reg          blank_hold_q;
    reg  [2:0]   blank_pipe_q;
    reg          shift_run_q;

    // dot side state
    reg  [3:0]   pidx_q;
    reg          seq_run_q;
    reg  [3:0]   div_q;
    reg          dot_en_q;
    reg  [4:0]   acc_q;

    // vga side
    reg  [10:0]  vga_hold_q;

    wire [65:0]  link_lvl;
    wire         lrise;
    wire         lfall;
    wire [11:0]  vga_lvl;
    wire         vrise;
    wire         vfall;

    wire         bus64     = mux_q[`MUX_BUS64_BIT];
    wire         five      = tcc_q[`TCC_FIVE_BIT];
    wire         shift_sel = tcc_q[`TCC_SHIFT_TIMING_BIT];
    wire [3:0]   n_pix     = grp_pixels(bus64, five);
    wire [3:0]   m_words   = grp_words(bus64, five);
    wire [1:0]   last_w    = m_words[1:0] - 2'd1;
    wire [1:0]   les       = (latch_q[1:0] > last_w) ? last_w : latch_q[1:0];
    // clocks per group: n_pix dots of three clocks each
    wire [4:0]   rclk_mod  = {n_pix, 1'b0} + {1'b0, n_pix};
    wire [23:0]  raw_pix   = seq_q[pidx_q*24 +: 24];
    wire         wb_req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire         blank_s   = blank_hold_q;
    wire         do_load;
    wire [1:0]   load_idx;

    pin_sync #(.W(66)) link_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .pin_i   ({pixel_bus_i, system_blank_in_i, pixel_load_clock_i}),
        .level_o (link_lvl),
        .rise_o  (lrise),
        .fall_o  (lfall)
    );

    pin_sync #(.W(12)) vga_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .pin_i   ({vga_pixel_in_i, vga_vsync_in_i, vga_hsync_in_i,
                   vga_blank_in_i, vga_clock_in_i}),
        .level_o (vga_lvl),
        .rise_o  (vrise),
        .fall_o  (vfall)
    );

    // wishbone slave, answers one cycle after the request
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            tcc_q    <= `RST_TRUE_COLOR_CTRL;
            mux_q    <= `RST_MUX_CTRL;
            misc_q   <= `RST_MISC_CTRL;
            clkc_q   <= `RST_CLOCK_CTRL;
            latch_q  <= `RST_LATCH_CTRL;
        end else begin
            wb_ack_o <= wb_req;
            if (wb_req & wb_we_i & wb_sel_i[0]) begin
                case (wb_adr_i)
                    `OFS_TRUE_COLOR_CTRL: tcc_q   <= wb_dat_i[7:0];
                    `OFS_MUX_CTRL:        mux_q   <= wb_dat_i[7:0];
                    `OFS_MISC_CTRL:       misc_q  <= wb_dat_i[7:0];
                    `OFS_CLOCK_CTRL:      clkc_q  <= wb_dat_i[7:0];
                    `OFS_LATCH_CTRL:      latch_q <= wb_dat_i[7:0];
                    default: ;
                endcase
            end
            if (wb_req & ~wb_we_i) begin
                case (wb_adr_i)
                    `OFS_TRUE_COLOR_CTRL: wb_dat_o <= {24'h000000, tcc_q};
                    `OFS_MUX_CTRL:        wb_dat_o <= {24'h000000, mux_q};
                    `OFS_MISC_CTRL:       wb_dat_o <= {24'h000000, misc_q};
                    `OFS_CLOCK_CTRL:      wb_dat_o <= {24'h000000, clkc_q};
                    `OFS_LATCH_CTRL:      wb_dat_o <= {24'h000000, latch_q};
                    `OFS_STATUS:          wb_dat_o <= {16'h0000, have_group_q, seq_run_q,
                                                       shift_run_q, state_q, widx_q,
                                                       pidx_q, 4'h0};
                    default:              wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // bus and blanking are held at the load clock's fall, half a period after
    // the accelerator changed them, and used at the following rise
    always @(posedge clk_i) begin
        if (rst_i) begin
            bus_hold_q   <= 64'h0000_0000_0000_0000;
            blank_hold_q <= 1'b0;
        end else if (lfall) begin
            bus_hold_q   <= link_lvl[65:2];
            blank_hold_q <= link_lvl[1];
        end
    end

    assign do_load  = lrise & ((state_q == ST_ACT & blank_s) |
                               (state_q == ST_IDLE & blank_s & ~shift_sel) |
                               (state_q == ST_WAIT & blank_s & wait_cnt_q));
    assign load_idx = (state_q == ST_ACT) ? widx_q : 2'd0;

    always @(posedge clk_i) begin
        if (rst_i) begin
            state_q      <= ST_IDLE;
            wait_cnt_q   <= 1'b0;
            widx_q       <= 2'd0;
            asm_q        <= 192'h0;
            group_q      <= 192'h0;
            have_group_q <= 1'b0;
            blank_pipe_q <= 3'b000;
            shift_run_q  <= 1'b0;
        end else if (lrise) begin
            blank_pipe_q <= {blank_pipe_q[1:0], blank_s};
            case (state_q)
                ST_IDLE: begin
                    widx_q <= 2'd0;
                    if (blank_s & shift_sel) begin
                        state_q     <= ST_WAIT;
                        wait_cnt_q  <= 1'b0;
                        shift_run_q <= 1'b1;
                    end else if (blank_s) begin
                        state_q <= ST_ACT;
                    end
                end
                ST_WAIT: begin
                    if (~blank_s) begin
                        state_q     <= ST_IDLE;
                        shift_run_q <= 1'b0;
                    end else if (wait_cnt_q) begin
                        state_q <= ST_ACT;
                    end else begin
                        wait_cnt_q <= 1'b1;
                    end
                end
                ST_ACT: begin
                    if (~blank_s) begin
                        state_q     <= ST_IDLE;
                        shift_run_q <= 1'b0;
                        widx_q      <= 2'd0;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
            if (do_load) begin
                if (bus64)
                    asm_q[load_idx*64 +: 64] <= bus_hold_q;
                else
                    asm_q[load_idx*32 +: 32] <= bus_hold_q[31:0];
                if (load_idx == last_w) begin
                    widx_q       <= 2'd0;
                    have_group_q <= 1'b1;
                    if (bus64)
                        group_q <= (asm_q & ~({128'h0, {64{1'b1}}} << (load_idx * 64)))
                                   | ({128'h0, bus_hold_q} << (load_idx * 64));
                    else
                        group_q <= {64'h0, asm_q[127:0] & ~({96'h0, 32'hffff_ffff}
                                   << (load_idx * 32))}
                                   | ({160'h0, bus_hold_q[31:0]} << (load_idx * 32));
                end else begin
                    widx_q <= load_idx + 2'd1;
                end
            end
        end
    end

    // dot sequencer: the edge chosen by the edge delay restarts the dot divider
    always @(posedge clk_i) begin
        if (rst_i) begin
            div_q     <= 4'd0;
            dot_en_q  <= 1'b0;
            pidx_q    <= 4'd0;
            seq_run_q <= 1'b0;
            seq_q     <= 192'h0;
            pixel_o   <= 24'h000000;
            pixel_valid_o <= 1'b0;
        end else begin
            if (do_load & (load_idx == les) & have_group_q) begin
                div_q     <= 4'd0;
                // first dot on the next clock, else an 8:3 group overruns its three loads
                dot_en_q  <= 1'b1;
                pidx_q    <= 4'd0;
                seq_run_q <= 1'b1;
                seq_q     <= group_q;
            end else begin
                dot_en_q <= (div_q == `DOT_DIV - 1);
                div_q    <= (div_q == `DOT_DIV - 1) ? 4'd0 : div_q + 4'd1;
                if (dot_en_q & seq_run_q) begin
                    pidx_q <= pidx_q + 4'd1;
                    if (pidx_q == n_pix - 4'd1)
                        seq_run_q <= 1'b0;
                end
            end
            pixel_valid_o <= dot_en_q & seq_run_q;
            if (dot_en_q & seq_run_q) begin
                if (tcc_q[`TCC_BGR_BIT])
                    pixel_o <= {raw_pix[7:0], raw_pix[15:8], raw_pix[23:16]};
                else
                    pixel_o <= {raw_pix[23:16], raw_pix[15:8], raw_pix[7:0]};
            end
        end
    end

    // return clock: rate generator stepped every clock, 2M against 3N, so the
    // faster 32-bit ratios still fit; in the five-pixel ratios one level is a clock short every other
    // period at 5:2 and every fourth period at 5:4, so duty is 7 or 8 in 15
    always @(posedge clk_i) begin
        if (rst_i) begin
            acc_q          <= 5'd0;
            return_clock_o <= 1'b0;
        end else if (clkc_q[`CLK_RCLK_SRC_BIT]) begin
            if (acc_q + {m_words, 1'b0} >= rclk_mod) begin
                acc_q          <= acc_q + {m_words, 1'b0} - rclk_mod;
                return_clock_o <= ~return_clock_o;
            end else begin
                acc_q <= acc_q + {m_words, 1'b0};
            end
        end else if (dot_en_q) begin
            acc_q          <= 5'd0;
            return_clock_o <= ~return_clock_o;
        end
    end

    // shift clock, blanking pipeline and colour path
    always @(posedge clk_i) begin
        if (rst_i) begin
            shift_clock_o        <= 1'b0;
            blank_o              <= 1'b0;
            palette_lookup_o     <= 1'b1;
            port_select_enable_o <= 1'b0;
        end else begin
            shift_clock_o        <= shift_sel & shift_run_q & link_lvl[0];
            blank_o              <= shift_sel ? blank_pipe_q[2] : blank_pipe_q[0];
            palette_lookup_o     <= ~misc_q[`MISC_BYPASS_BIT];
            port_select_enable_o <= misc_q[`MISC_PORT_SEL_BIT];
        end
    end

    // legacy VGA port, latched on the VGA clock unless the latch select is set
    always @(posedge clk_i) begin
        if (rst_i) begin
            vga_hold_q   <= 11'h000;
            vga_pixel_o  <= 8'h00;
            vga_blank_o  <= 1'b0;
            vga_hsync_o  <= 1'b0;
            vga_vsync_o  <= 1'b0;
            vga_source_o <= 1'b1;
        end else begin
            vga_source_o <= mux_q[`MUX_VGA_MODE_BIT];
            if (mux_q[`MUX_VGA_LATCH_BIT] ? lfall : vfall)
                vga_hold_q <= vga_lvl[11:1];
            if (mux_q[`MUX_VGA_LATCH_BIT] ? lrise : vrise) begin
                vga_pixel_o <= vga_hold_q[10:3];
                vga_vsync_o <= vga_hold_q[2];
                vga_hsync_o <= vga_hold_q[1];
                vga_blank_o <= vga_hold_q[0];
            end
        end
    end
endmodule

// file: inc/packed24_pixel_unpacker_map.vh
/*
 * Register offsets, field positions, reset values and timing counts of the
 * packed 24-bit pixel unpacker.
 * Assumes a 32-bit classic Wishbone slave, one register per aligned word.
 */
`ifndef PACKED24_PIXEL_UNPACKER_MAP_VH
`define PACKED24_PIXEL_UNPACKER_MAP_VH

// byte offsets
`define OFS_TRUE_COLOR_CTRL   8'h00
`define OFS_MUX_CTRL          8'h04
`define OFS_MISC_CTRL         8'h08
`define OFS_CLOCK_CTRL        8'h0c
`define OFS_LATCH_CTRL        8'h10
`define OFS_STATUS            8'h14

// reset values
`define RST_TRUE_COLOR_CTRL   8'h80
`define RST_MUX_CTRL          8'h98
`define RST_MISC_CTRL         8'h00
`define RST_CLOCK_CTRL        8'h00
`define RST_LATCH_CTRL        8'h00

// true colour control fields
`define TCC_BGR_BIT           0
`define TCC_FIVE_BIT          3
`define TCC_SHIFT_TIMING_BIT  5
// multiplex control fields
`define MUX_BUS64_BIT         2
`define MUX_VGA_LATCH_BIT     6
`define MUX_VGA_MODE_BIT      7
// misc control fields
`define MISC_PORT_SEL_BIT     4
`define MISC_BYPASS_BIT       5
// clock control fields
`define CLK_RCLK_SRC_BIT      5

// timing
`define CLK_PERIOD_NS         100
`define DOT_PERIOD_NS         300
`define DOT_DIV               (`DOT_PERIOD_NS / `CLK_PERIOD_NS)
`define SHIFT_LOAD_DELAY      2

`endif

// file: hw/pin_sync.v
/*
 * Three-stage synchroniser for a group of pins from outside the clock domain.
 * A level is taken once the second and third stages agree; bit 0 also gives
 * rise and fall pulses. Assumes clk_i is much faster than the pin's changes.
 */
module pin_sync #(
    parameter W = 1
) (
    input  wire         clk_i,
    input  wire         rst_i,
    input  wire [W-1:0] pin_i,
    output reg  [W-1:0] level_o,
    output reg          rise_o,
    output reg          fall_o
);
    reg [W-1:0] s1_q;
    reg [W-1:0] s2_q;
    reg [W-1:0] s3_q;
    integer     i;

    always @(posedge clk_i) begin
        if (rst_i) begin
            s1_q    <= {W{1'b0}};
            s2_q    <= {W{1'b0}};
            s3_q    <= {W{1'b0}};
            level_o <= {W{1'b0}};
            rise_o  <= 1'b0;
            fall_o  <= 1'b0;
        end else begin
            s1_q <= pin_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            for (i = 0; i < W; i = i + 1) begin
                if (s2_q[i] == s3_q[i])
                    level_o[i] <= s3_q[i];
            end
            rise_o <= (s2_q[0] & s3_q[0]) & ~level_o[0];
            fall_o <= ~(s2_q[0] | s3_q[0]) & level_o[0];
        end
    end
endmodule

// file: verif/pixel_unpacker_checker.sv
/* port checker for the packed 24-bit pixel unpacker.
   assumes one clock domain, clk_i, with synchronous active-high rst_i. */
module pixel_unpacker_checker (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o,
    input wire logic        pixel_load_clock_i,
    input wire logic        vga_clock_in_i,
    input wire logic        return_clock_o,
    input wire logic        shift_clock_o,
    input wire logic [23:0] pixel_o,
    input wire logic        pixel_valid_o,
    input wire logic        blank_o,
    input wire logic        palette_lookup_o,
    input wire logic        port_select_enable_o,
    input wire logic        vga_source_o,
    input wire logic [7:0]  vga_pixel_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_ack_next;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack_next: assert property (p_ack_next) else $error("ack late");
    property p_ack_drop;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_drop: assert property (p_ack_drop) else $error("ack held");
    property p_valid_gap;
        pixel_valid_o |=> !pixel_valid_o [*2];
    endproperty
    a_valid_gap: assert property (p_valid_gap) else $error("pixels too close");
    property p_rclk_rate;
        $changed(return_clock_o) [*2] |=> $stable(return_clock_o);
    endproperty
    a_rclk_rate: assert property (p_rclk_rate) else $error("return clock too fast");
    property p_pix_hold;
        $changed(pixel_o) |-> pixel_valid_o;
    endproperty
    a_pix_hold: assert property (p_pix_hold) else $error("pixel moved");
    // own disable: this one looks at the reset itself
    property p_rst_vals;
        disable iff (1'b0) rst_i |=> palette_lookup_o && vga_source_o
            && !port_select_enable_o && !shift_clock_o && !pixel_valid_o;
    endproperty
    a_rst_vals: assert property (p_rst_vals) else $error("reset values");
    property p_vga_still;
        ($stable(vga_clock_in_i) && $stable(pixel_load_clock_i)) [*8]
            |=> $stable(vga_pixel_o);
    endproperty
    a_vga_still: assert property (p_vga_still) else $error("vga latch no clock");
    property p_valid_blank;
        pixel_valid_o |-> blank_o;
    endproperty
    a_valid_blank: assert property (p_valid_blank) else $error("pixel in blank");
    property p_pal_bus;
        $changed(palette_lookup_o) |-> wb_ack_o || $past(wb_ack_o);
    endproperty
    a_pal_bus: assert property (p_pal_bus) else $error("palette mode no write");
endmodule

bind packed24_pixel_unpacker pixel_unpacker_checker pixel_unpacker_checker_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .pixel_load_clock_i(pixel_load_clock_i),
    .vga_clock_in_i(vga_clock_in_i), .return_clock_o(return_clock_o),
    .shift_clock_o(shift_clock_o), .pixel_o(pixel_o), .pixel_valid_o(pixel_valid_o),
    .blank_o(blank_o), .palette_lookup_o(palette_lookup_o),
    .port_select_enable_o(port_select_enable_o), .vga_source_o(vga_source_o),
    .vga_pixel_o(vga_pixel_o));

// file: verif/pixel_source_model.sv
/* accelerator model: makes load clock, blanking and pixel bus for two lines.
   assumes start_i rises once per run and the mode inputs hold during it. */
module pixel_source_model (
    input  wire logic        start_i,
    input  wire logic        bus64_i,
    input  wire logic        five_i,
    input  wire logic        shift_i,
    output logic             pixel_load_clock_o,
    output logic             blank_o,
    output logic [63:0]      bus_o,
    output logic             done_o
);
    timeunit 1ns;
    timeprecision 1ns;
    int m;
    int lead;
    initial begin
        pixel_load_clock_o = 1'b0;
        blank_o = 1'b0;
        bus_o = '0;
        done_o = 1'b0;
    end
    function automatic logic [63:0] word(input int g, input int w);
        logic [63:0] v;
        for (int j = 0; j < 8; j++) v[8*j +: 8] = 8'(w * (bus64_i ? 8 : 4) + j + 64 * g);
        if (!bus64_i) v[63:32] = ~v[31:0];
        return v;
    endfunction
    // the clock stands still between runs
    always @(posedge start_i) begin
        m = bus64_i ? (five_i ? 2 : 3) : (five_i ? 4 : 3);
        lead = shift_i ? 2 : 0;
        done_o = 1'b0;
        #20; // keep load-clock edges off the sampling clock edges
        for (int line = 0; line < 2; line++) begin
            for (int i = 0; i < 4 * m; i++) begin
                pixel_load_clock_o = 1'b1;
                #1;
                blank_o = i < lead + 2 * m;
                if (i >= lead && i < lead + 2 * m) begin
                    bus_o = word((i - lead) / m, (i - lead) % m);
                end else begin
                    bus_o = ~bus_o; // a released bus shows no stale word
                end
                #399;
                pixel_load_clock_o = 1'b0;
                #400;
            end
        end
        done_o = 1'b1;
    end
endmodule

// file: verif/packed24_pixel_unpacker_tb.sv
/* self-checking bench: registers over classic Wishbone, VGA latch and all
   four packed ratios. assumes the accelerator model in pixel_source_model. */
module packed24_pixel_unpacker_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_i = 0, rst_i = 1, wb_we_i = 0, wb_cyc_i = 0, wb_stb_i = 0;
    logic [7:0]  wb_adr_i = '0, vga_pixel_in_i = '0, vga_pixel_o, b;
    logic [31:0] wb_dat_i = '0, wb_dat_o;
    logic [3:0]  wb_sel_i = '0;
    logic        vga_clock_in_i = 0, vga_blank_in_i = 0, vga_hsync_in_i = 0;
    logic        vga_vsync_in_i = 0, pixel_load_clock_i, system_blank_in_i, wb_ack_o;
    logic [63:0] pixel_bus_i;
    logic [23:0] pixel_o;
    logic        return_clock_o, shift_clock_o, pixel_valid_o, blank_o, palette_lookup_o;
    logic        port_select_enable_o, vga_source_o, vga_blank_o, vga_hsync_o, vga_vsync_o;
    logic        start = 0, bus64 = 0, five = 0, shift_m = 0, done, bgr = 0, rc_q = 0;
    int          n_errors = 0, checked = 0, cyc_cnt = 0, rises, npix, n_pix = 8, shift_seen;
    logic [7:0]  ofs [5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
    logic [7:0]  rstv [5] = '{8'h80, 8'h98, 8'h00, 8'h00, 8'h00};

    packed24_pixel_unpacker packed24_pixel_unpacker_i (.*);
    pixel_source_model pixel_source_model_i (.start_i(start), .bus64_i(bus64),
        .five_i(five), .shift_i(shift_m), .pixel_load_clock_o(pixel_load_clock_i),
        .blank_o(system_blank_in_i), .bus_o(pixel_bus_i), .done_o(done));

    always #50 clk_i = ~clk_i;

    task automatic close_out();
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] s);
        checked++;
        if (s !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", what, e, s);
            n_errors++;
        end
    endtask
    task automatic bus(input logic [7:0] a, input logic we, input logic [31:0] d,
                       input logic [3:0] s, output logic [31:0] q);
        wb_adr_i <= a;
        wb_we_i <= we;
        wb_dat_i <= d;
        wb_sel_i <= s;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(a, 1'b1, d, 4'hf, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(a, 1'b0, 32'h0, 4'hf, q);
        chk("register read", e, q);
    endtask
    task automatic reset();
        rst_i <= 1'b1;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic run(input logic b64, fv, bg, sh, input logic [1:0] dl);
        int e;
        reset();
        wr(8'h00, 32'({sh, 1'b0, fv, 2'b00, bg}));
        wr(8'h04, 32'({b64, 2'b00}));
        wr(8'h10, 32'(dl));
        wr(8'h08, 32'h20);
        wr(8'h0c, 32'h20);
        bus64 = b64;
        five = fv;
        shift_m = sh;
        bgr = bg;
        n_pix = b64 ? (fv ? 5 : 8) : (fv ? 5 : 4);
        e = 800 * (b64 ? (fv ? 2 : 3) : (fv ? 4 : 3)) / n_pix;
        rises = 0;
        repeat (2400) @(posedge clk_i);
        checked++;
        if (rises < e - 1 || rises > e + 1) begin
            $display("CHECK FAILED return clock rises expected %0d seen %0d", e, rises);
            n_errors++;
        end
        npix = 0;
        shift_seen = 0;
        start <= 1'b1;
        @(posedge clk_i);
        start <= 1'b0;
        while (done !== 1'b1) @(posedge clk_i);
        repeat (100) @(posedge clk_i);
        chk("pixel count", 3 * n_pix, npix);
        chk("shift clock used", 32'(sh), shift_seen);
    endtask

    always @(posedge clk_i) begin
        rc_q <= return_clock_o;
        if (return_clock_o === 1'b1 && rc_q === 1'b0) rises++;
        if (shift_clock_o === 1'b1) shift_seen = 1;
        if (pixel_valid_o === 1'b1) begin
            b = 8'(3 * (npix % n_pix) + 64 * ((npix / n_pix) % 2));
            chk("pixel", bgr ? {b, 8'(b + 1), 8'(b + 2)} : {8'(b + 2), 8'(b + 1), b},
                pixel_o);
            npix++;
        end
        cyc_cnt++;
        if (cyc_cnt == 40000) begin
            n_errors++;
            close_out();
        end
    end

    initial begin
        logic [31:0] q;
        reset();
        for (int i = 0; i < 5; i++) rd(ofs[i], 32'(rstv[i]));
        rd(8'h14, 32'h400);
        chk("selects", 3'b110, {palette_lookup_o, vga_source_o, port_select_enable_o});
        wr(8'h18, 32'hff);
        rd(8'h18, 32'h0);
        bus(8'h08, 1'b1, 32'h30, 4'h0, q);
        rd(8'h08, 32'h0);
        wr(8'h08, 32'h30);
        repeat (2) @(posedge clk_i);
        chk("bypass and port", 2'b01, {palette_lookup_o, port_select_enable_o});
        vga_pixel_in_i <= 8'h5a;
        vga_hsync_in_i <= 1'b1;
        vga_blank_in_i <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            vga_clock_in_i <= ~vga_clock_in_i;
            repeat (8) @(posedge clk_i);
        end
        chk("vga latch", {8'h5a, 3'b011},
            {vga_pixel_o, vga_vsync_o, vga_hsync_o, vga_blank_o});
        run(1'b1, 1'b0, 1'b0, 1'b0, 2'd0);
        run(1'b1, 1'b1, 1'b1, 1'b0, 2'd0);
        run(1'b0, 1'b0, 1'b0, 1'b0, 2'd0);
        run(1'b0, 1'b1, 1'b1, 1'b0, 2'd0);
        run(1'b1, 1'b0, 1'b1, 1'b1, 2'd1);
        close_out();
    end
endmodule
